// ===== inc/pmsc_pkg.sv
// Constants, register map and state type of the power management block.
// Assumes a 200 MHz clock and a 32-bit APB register bus.
package pmsc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus and register map
   localparam int unsigned APB_ADDR_W          = 8;
   localparam int unsigned APB_DATA_W          = 32;
   localparam logic [7:0]  OFF_CONTROL         = 8'h00;
   localparam logic [7:0]  OFF_SOURCE_EN       = 8'h04;
   localparam logic [7:0]  OFF_REQ_STATUS      = 8'h08;
   localparam logic [7:0]  OFF_EVENT_EN        = 8'h0c;
   localparam logic [7:0]  OFF_IDLE_START      = 8'h10;
   localparam logic [7:0]  OFF_IDLE_COUNT      = 8'h14;
   localparam logic [7:0]  OFF_NEG_INTERVAL    = 8'h18;
   localparam logic [7:0]  OFF_ASSERT_INTERVAL = 8'h1c;
   localparam logic [7:0]  OFF_OS_COMMAND      = 8'h20;
   localparam logic [7:0]  OFF_OS_STATUS       = 8'h24;
   localparam logic [7:0]  OFF_INT_STATUS      = 8'h28;
   localparam logic [7:0]  OFF_INT_MASK        = 8'h2c;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int unsigned CTL_GLOBAL_EN       = 0;
   localparam int unsigned CTL_STOP_EN         = 1;
   localparam int unsigned CTL_SCALE_EN        = 2;
   localparam int unsigned CTL_RATE_LSB        = 4;
   localparam int unsigned RATE_W              = 2;
   localparam int unsigned NUM_IRQ_PINS        = 5;
   localparam int unsigned NUM_PINS            = 6;
   localparam int unsigned NUM_SRC             = 8;
   localparam int unsigned SRC_IDLE            = 6;
   localparam int unsigned SRC_OSCMD           = 7;
   localparam int unsigned EVT_SYS_LSB         = 0;
   localparam int unsigned EVT_BRK_LSB         = 8;
   localparam int unsigned INT_STOP_ON         = 0;
   localparam int unsigned INT_STOP_OFF        = 1;
   localparam int unsigned INT_MGMT            = 2;
   localparam int unsigned NUM_INT             = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and pin polarity
   localparam logic [7:0]  RST_BYTE            = 8'h00;
   localparam logic [5:0]  RST_PINS6           = 6'h00;
   localparam logic [2:0]  RST_INT3            = 3'h0;
   // Pins 3 (irq line 8) and 5 (external request) are active low
   localparam logic [5:0]  PIN_ACTIVE_LOW      = 6'h28;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_MHZ             = 200;
   localparam int unsigned TICK_US             = 32;
   localparam int unsigned TICK_CYCLES         = TICK_US * CLK_MHZ;
   localparam int unsigned PRESCALE_W          = 6;
   localparam logic [5:0]  RATE_LIMIT [4]      = '{6'h00, 6'h03, 6'h0f, 6'h3f};

   typedef enum logic [1:0]
   {
      ST_RUN        = 2'b00,
      ST_SCALE_RUN  = 2'b01,
      ST_SCALE_STOP = 2'b11,
      ST_STOP       = 2'b10
   } pmsc_stop_state_t;

endpackage : pmsc_pkg

// ===== rtl/pmsc_tick_div.sv
// Divider that makes the one-cycle interval tick from the system clock.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pmsc_tick_div #(
   parameter int unsigned DIV = 6400
) (
   input  wire logic clk,     // System clock
   input  wire logic sys_rst, // Synchronous reset
   output logic      tick     // One-cycle tick every DIV clocks
);
   localparam int unsigned CW   = (DIV < 2) ? 1 : $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   if (DIV < 2)
   begin : g_bad_div
      $error("pmsc_tick_div: DIV must be at least 2");
   end

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic          next_tick;

   always_comb
   begin
      next_tick  = (count == LAST);
      next_count = next_tick ? '0 : count + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         count <= '0;
         tick  <= 1'b0;
      end
      else
      begin
         count <= next_count;
         tick  <= next_tick;
      end
   end
endmodule : pmsc_tick_div

// ===== rtl/pmsc_top.sv
// Power management block: management interrupt sources and CPU stop-clock control.
// Assumes APB on clk, asynchronous pins for interrupt lines and the external request.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module pmsc_top
   import pmsc_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES
) (
   input  wire logic                  clk,                // System clock
   input  wire logic                  sys_rst,            // Synchronous reset
   input  wire logic                  psel,               // APB select
   input  wire logic                  penable,            // APB enable
   input  wire logic                  pwrite,             // APB write
   input  wire logic [APB_ADDR_W-1:0] paddr,              // APB byte address
   input  wire logic [APB_DATA_W-1:0] pwdata,             // APB write data
   output logic      [APB_DATA_W-1:0] prdata,             // APB read data
   output logic                       pready,             // APB ready
   output logic                       pslverr,            // APB error
   input  wire logic [4:0]            irqLinePin,         // Lines 1,3,4,8(low),12
   input  wire logic                  ext_mgmt_request_n, // External request
   output logic                       mgmt_irq_n,         // Management interrupt
   output logic                       cpu_stop_clock_n,   // CPU stop-clock
   output logic                       intReq              // Block interrupt
);

   if (TICK_DIV < 2)
   begin : g_bad_tick
      $error("pmsc_top: TICK_DIV must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tick
   logic tick;

   pmsc_tick_div #(
      .DIV     (TICK_DIV)
   ) u_tick (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and event detect
   logic [NUM_PINS-1:0] syncA;
   logic [NUM_PINS-1:0] syncB;
   logic [NUM_PINS-1:0] syncC;
   logic [NUM_PINS-1:0] pinLevel;
   logic [NUM_PINS-1:0] activePrev;
   logic [NUM_PINS-1:0] next_pinLevel;
   logic [NUM_PINS-1:0] active;
   logic [NUM_PINS-1:0] pinEvent;
   logic [NUM_PINS-1:0] agree;

   always_comb
   begin
      agree         = ~(syncB ^ syncC);
      next_pinLevel = (syncC & agree) | (pinLevel & ~agree);
      active        = pinLevel ^ PIN_ACTIVE_LOW;
      pinEvent      = active & ~activePrev;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         syncA      <= PIN_ACTIVE_LOW;
         syncB      <= PIN_ACTIVE_LOW;
         syncC      <= PIN_ACTIVE_LOW;
         pinLevel   <= PIN_ACTIVE_LOW;
         activePrev <= RST_PINS6;
      end
      else
      begin
         syncA      <= {ext_mgmt_request_n, irqLinePin};
         syncB      <= syncA;
         syncC      <= syncB;
         pinLevel   <= next_pinLevel;
         activePrev <= active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave and registers
   logic [7:0]          control;
   logic [7:0]          srcEnable;
   logic [7:0]          reqStatus;
   logic [5:0]          sysEvtEn;
   logic [5:0]          brkEvtEn;
   logic [7:0]          idleStart;
   logic [7:0]          idleCount;
   logic [7:0]          negInterval;
   logic [7:0]          assertInterval;
   logic [7:0]          osCommand;
   logic [7:0]          osStatus;
   logic [NUM_INT-1:0]  intStatus;
   logic [NUM_INT-1:0]  intMask;
   logic [7:0]          next_control;
   logic [7:0]          next_srcEnable;
   logic [7:0]          next_reqStatus;
   logic [5:0]          next_sysEvtEn;
   logic [5:0]          next_brkEvtEn;
   logic [7:0]          next_idleStart;
   logic [7:0]          next_negInterval;
   logic [7:0]          next_assertInterval;
   logic [7:0]          next_osCommand;
   logic [7:0]          next_osStatus;
   logic [NUM_INT-1:0]  next_intStatus;
   logic [NUM_INT-1:0]  next_intMask;
   logic [31:0]         next_prdata;
   logic                next_pready;
   logic                next_pslverr;
   logic                next_mgmt_irq_n;
   logic                next_intReq;
   logic                next_stopN;
   logic                accessFirst;
   logic                done;
   logic                writeDone;
   logic                osRead;
   logic                osWrite;
   logic                idleWrite;
   logic                idleFire;
   logic [NUM_SRC-1:0]  reqSet;
   logic [NUM_SRC-1:0]  reqClear;
   logic [NUM_INT-1:0]  intSet;
   logic [NUM_INT-1:0]  intClear;

   always_comb
   begin
      accessFirst = psel & penable & ~pready;
      done        = psel & penable & pready;
      writeDone   = done & pwrite;
      // Ports live only on this bus; no other master path exists
      osRead      = done & ~pwrite & (paddr == OFF_OS_COMMAND);
      osWrite     = writeDone & (paddr == OFF_OS_COMMAND);
      idleWrite   = writeDone & (paddr == OFF_IDLE_START);
      next_pready  = accessFirst;
      next_pslverr = 1'b0;
      next_prdata  = prdata;
      if (accessFirst)
      begin
         next_prdata = 32'h0000_0000;
         case (paddr)
            OFF_CONTROL:         next_prdata[7:0]  = control;
            OFF_SOURCE_EN:       next_prdata[7:0]  = srcEnable;
            OFF_REQ_STATUS:      next_prdata[7:0]  = reqStatus;
            OFF_EVENT_EN:        next_prdata[13:0] = {brkEvtEn, 2'b00, sysEvtEn};
            OFF_IDLE_START:      next_prdata[7:0]  = idleStart;
            OFF_IDLE_COUNT:      next_prdata[7:0]  = idleCount;
            OFF_NEG_INTERVAL:    next_prdata[7:0]  = negInterval;
            OFF_ASSERT_INTERVAL: next_prdata[7:0]  = assertInterval;
            OFF_OS_COMMAND:      next_prdata[7:0]  = osCommand;
            OFF_OS_STATUS:       next_prdata[7:0]  = osStatus;
            OFF_INT_STATUS:      next_prdata[2:0]  = intStatus;
            OFF_INT_MASK:        next_prdata[2:0]  = intMask;
            default:             next_pslverr      = 1'b1;
         endcase
      end
      next_control        = control;
      next_srcEnable      = srcEnable;
      next_sysEvtEn       = sysEvtEn;
      next_brkEvtEn       = brkEvtEn;
      next_idleStart      = idleStart;
      next_negInterval    = negInterval;
      next_assertInterval = assertInterval;
      next_osCommand      = osCommand;
      next_osStatus       = osStatus;
      next_intMask        = intMask;
      reqClear            = '0;
      intClear            = '0;
      if (writeDone)
      begin
         case (paddr)
            OFF_CONTROL:         next_control        = pwdata[7:0];
            OFF_SOURCE_EN:       next_srcEnable      = pwdata[7:0];
            OFF_REQ_STATUS:      reqClear            = pwdata[7:0];
            OFF_EVENT_EN:
            begin
               next_sysEvtEn = pwdata[EVT_SYS_LSB +: NUM_PINS];
               next_brkEvtEn = pwdata[EVT_BRK_LSB +: NUM_PINS];
            end
            OFF_IDLE_START:      next_idleStart      = pwdata[7:0];
            OFF_NEG_INTERVAL:    next_negInterval    = pwdata[7:0];
            OFF_ASSERT_INTERVAL: next_assertInterval = pwdata[7:0];
            OFF_OS_COMMAND:      next_osCommand      = pwdata[7:0];
            OFF_OS_STATUS:       next_osStatus       = pwdata[7:0];
            OFF_INT_STATUS:      intClear            = pwdata[NUM_INT-1:0];
            OFF_INT_MASK:        next_intMask        = pwdata[NUM_INT-1:0];
            default:             next_control        = control;
         endcase
      end
      // Enabled sources only; a new event wins over a same-cycle clear
      reqSet          = {osWrite, idleFire, pinEvent} & srcEnable;
      next_reqStatus  = (reqStatus & ~reqClear) | reqSet;
      next_mgmt_irq_n = ~(control[CTL_GLOBAL_EN] & |(reqStatus & srcEnable));
      intSet[INT_STOP_ON]  = cpu_stop_clock_n & ~next_stopN;
      intSet[INT_STOP_OFF] = ~cpu_stop_clock_n & next_stopN;
      intSet[INT_MGMT]     = mgmt_irq_n & ~next_mgmt_irq_n;
      next_intStatus  = (intStatus & ~intClear) | intSet;
      next_intReq     = |(intStatus & intMask);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         control        <= RST_BYTE;
         srcEnable      <= RST_BYTE;
         reqStatus      <= RST_BYTE;
         sysEvtEn       <= RST_PINS6;
         brkEvtEn       <= RST_PINS6;
         idleStart      <= RST_BYTE;
         negInterval    <= RST_BYTE;
         assertInterval <= RST_BYTE;
         osCommand      <= RST_BYTE;
         osStatus       <= RST_BYTE;
         intStatus      <= RST_INT3;
         intMask        <= RST_INT3;
         prdata         <= 32'h0000_0000;
         pready         <= 1'b0;
         pslverr        <= 1'b0;
         mgmt_irq_n     <= 1'b1;
         intReq         <= 1'b0;
      end
      else
      begin
         control        <= next_control;
         srcEnable      <= next_srcEnable;
         reqStatus      <= next_reqStatus;
         sysEvtEn       <= next_sysEvtEn;
         brkEvtEn       <= next_brkEvtEn;
         idleStart      <= next_idleStart;
         negInterval    <= next_negInterval;
         assertInterval <= next_assertInterval;
         osCommand      <= next_osCommand;
         osStatus       <= next_osStatus;
         intStatus      <= next_intStatus;
         intMask        <= next_intMask;
         prdata         <= next_prdata;
         pready         <= next_pready;
         pslverr        <= next_pslverr;
         mgmt_irq_n     <= next_mgmt_irq_n;
         intReq         <= next_intReq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Idle timer
   logic                  idleArmed;
   logic [PRESCALE_W-1:0] preCount;
   logic                  next_idleArmed;
   logic [7:0]            next_idleCount;
   logic [PRESCALE_W-1:0] next_preCount;
   logic [PRESCALE_W-1:0] rateLimit;
   logic                  step;
   logic                  reload;

   always_comb
   begin
      rateLimit = RATE_LIMIT[control[CTL_RATE_LSB +: RATE_W]];
      step      = tick & (preCount == rateLimit);
      reload    = idleWrite | (|(pinEvent & sysEvtEn));
      // A zero start value fires at the first step
      idleFire  = idleArmed & ~reload & step & (idleCount <= 8'h01);
      next_idleArmed = idleArmed;
      next_idleCount = idleCount;
      next_preCount  = preCount;
      if (reload)
      begin
         next_idleArmed = 1'b1;
         next_idleCount = idleWrite ? pwdata[7:0] : idleStart;
         next_preCount  = '0;
      end
      else if (idleArmed)
      begin
         if (tick)
         begin
            next_preCount = step ? '0 : preCount + 1'b1;
         end
         if (idleFire)
         begin
            next_idleArmed = 1'b0;
            next_idleCount = 8'h00;
         end
         else if (step)
         begin
            next_idleCount = idleCount - 8'h01;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         idleArmed <= 1'b0;
         idleCount <= RST_BYTE;
         preCount  <= '0;
      end
      else
      begin
         idleArmed <= next_idleArmed;
         idleCount <= next_idleCount;
         preCount  <= next_preCount;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stop-clock control
   pmsc_stop_state_t state;
   pmsc_stop_state_t next_state;
   logic [7:0]       intervalCount;
   logic [7:0]       next_intervalCount;
   logic             breakEvt;
   logic             stopEn;
   logic             scaleEn;

   always_comb
   begin
      breakEvt           = |(pinEvent & brkEvtEn);
      stopEn             = control[CTL_STOP_EN];
      scaleEn            = control[CTL_SCALE_EN];
      next_state         = state;
      next_intervalCount = intervalCount;
      case (state)
         ST_RUN:
         begin
            if (stopEn & osRead)
            begin
               next_state = ST_STOP;
            end
            else if (scaleEn)
            begin
               next_state         = ST_SCALE_RUN;
               next_intervalCount = negInterval;
            end
         end
         ST_STOP:
         begin
            if (breakEvt | ~stopEn | osWrite)
            begin
               next_state = ST_RUN;
            end
         end
         ST_SCALE_RUN:
         begin
            if (~scaleEn)
            begin
               next_state = ST_RUN;
            end
            else if (intervalCount == 8'h00)
            begin
               next_state         = ST_SCALE_STOP;
               next_intervalCount = assertInterval;
            end
            else if (tick)
            begin
               next_intervalCount = intervalCount - 8'h01;
            end
         end
         ST_SCALE_STOP:
         begin
            if (~scaleEn | osWrite)
            begin
               next_state = ST_RUN;
            end
            else if (breakEvt | (intervalCount == 8'h00))
            begin
               next_state         = ST_SCALE_RUN;
               next_intervalCount = negInterval;
            end
            else if (tick)
            begin
               next_intervalCount = intervalCount - 8'h01;
            end
         end
         default:
         begin
            next_state = ST_RUN;
         end
      endcase
      // CPU model resumes two clocks after this goes high: one for the output register, one for its own
      next_stopN = ~((next_state == ST_STOP) | (next_state == ST_SCALE_STOP));
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state            <= ST_RUN;
         intervalCount    <= RST_BYTE;
         cpu_stop_clock_n <= 1'b1;
      end
      else
      begin
         state            <= next_state;
         intervalCount    <= next_intervalCount;
         cpu_stop_clock_n <= next_stopN;
      end
   end

endmodule : pmsc_top

// ===== testbench/pmsc_cpu_model.sv
// CPU model facing the block: stop-grant state.
// Assumes it shares the block's clock.
`timescale 1ns/1ps
module pmsc_cpu_model (
   input  wire logic clk,              // Clock
   input  wire logic cpu_stop_clock_n, // Stop-clock
   output logic      halted            // Stop-grant
);
   initial halted = 1'b0;
   // No acknowledge; resumes once negated
   always @(posedge clk) halted <= !cpu_stop_clock_n;
endmodule : pmsc_cpu_model

// ===== testbench/pmsc_top_sva.sv
// Port checker for the power management block.
// Assumes binding into pmsc_top.
`timescale 1ns/1ps
module pmsc_top_sva
   import pmsc_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES
) (
   input wire logic        clk,                // In
   input wire logic        sys_rst,            // In
   input wire logic        psel,               // In
   input wire logic        penable,            // In
   input wire logic        pwrite,             // In
   input wire logic [7:0]  paddr,              // In
   input wire logic [31:0] pwdata,             // In
   input wire logic [31:0] prdata,             // Out
   input wire logic        pready,             // Out
   input wire logic        pslverr,            // Out
   input wire logic [4:0]  irqLinePin,         // In
   input wire logic        ext_mgmt_request_n, // In
   input wire logic        mgmt_irq_n,         // Out
   input wire logic        cpu_stop_clock_n,   // Out
   input wire logic        intReq              // Out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire logic acc = psel && penable;
   wire logic wrDone = acc && pready && pwrite;
   wire logic bad = paddr[1:0] != 2'h0 || paddr > OFF_INT_MASK;
   reset_idle_a: assert property (disable iff (1'b0)
      sys_rst |=> mgmt_irq_n && cpu_stop_clock_n && !pready && !intReq) else $error("outputs not idle");
   wait_state_a: assert property (acc && !pready |=> pready) else $error("no answer");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
   ready_cause_a: assert property (pready |-> acc && $past(acc)) else $error("stray ready");
   err_decode_a: assert property (acc && !pready && bad |=> pslverr) else $error("no error");
   no_err_a: assert property (acc && !pready && !bad |=> !pslverr) else $error("false error");
   refused_read_a: assert property (pready && pslverr && !pwrite |-> prdata == '0)
      else $error("refused read not zero");
   cmd_release_a: assert property (wrDone && paddr == OFF_OS_COMMAND |=> ##[0:1] cpu_stop_clock_n)
      else $error("stop not released");
   irq_hold_a: assert property (!mgmt_irq_n && !wrDone && !$past(wrDone) |=> !mgmt_irq_n)
      else $error("interrupt dropped");
endmodule : pmsc_top_sva
bind pmsc_top pmsc_top_sva #(.TICK_DIV(TICK_DIV)) u_sva (.clk(clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irqLinePin(irqLinePin), .ext_mgmt_request_n(ext_mgmt_request_n),
   .mgmt_irq_n(mgmt_irq_n), .cpu_stop_clock_n(cpu_stop_clock_n), .intReq(intReq));

// ===== testbench/pmsc_top_tb.sv
// Bench for the power management block: APB master, pins, CPU model.
// Assumes TICK_DIV of 8 and the checker bound in.
`timescale 1ns/1ps
module pmsc_top_tb;
   import pmsc_pkg::*;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
   logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [5:0]  pins = PIN_ACTIVE_LOW;
   logic        pready, pslverr, mgmt_irq_n, cpu_stop_clock_n, intReq, err, halted;
   int          miscompares = 0, n_compared = 0, lowCnt;
   pmsc_top #(.TICK_DIV(8)) u_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irqLinePin(pins[4:0]), .ext_mgmt_request_n(pins[5]), .mgmt_irq_n,
      .cpu_stop_clock_n, .intReq);
   pmsc_cpu_model u_cpu (.clk, .cpu_stop_clock_n, .halted);
   initial forever #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a missing answer
      do @(posedge clk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : rdchk
   // Holds one pin at its active level past the filter
   task automatic pulse(input int i);
      pins <= PIN_ACTIVE_LOW ^ (6'h01 << i);
      cyc(12);
      pins <= PIN_ACTIVE_LOW;
      cyc(8);
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      `CHK({mgmt_irq_n, cpu_stop_clock_n, intReq}, 3'h6)
      for (int a = 0; a < 48; a += 4) rdchk(8'(a), 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      `CHK(err, 1'b1)
      apb(1'b1, 8'h01, 32'h1);
      `CHK(err, 1'b1)
   endtask : t_reset
   task automatic t_irq;
      wr(OFF_CONTROL, 32'h1);
      wr(OFF_SOURCE_EN, 32'h3f);
      for (int i = 0; i < 6; i++)
      begin
         pulse(i);
         `CHK(mgmt_irq_n, 1'b0)
         rdchk(OFF_REQ_STATUS, 32'h1 << i);
         `CHK(mgmt_irq_n, 1'b0)
         wr(OFF_REQ_STATUS, 32'h1 << i);
         cyc(2);
         `CHK(mgmt_irq_n, 1'b1)
      end
      wr(OFF_SOURCE_EN, 32'h1f);
      pulse(5);
      `CHK(mgmt_irq_n, 1'b1)
      wr(OFF_CONTROL, 32'h0);
      wr(OFF_SOURCE_EN, 32'h3f);
      pulse(0);
      `CHK(mgmt_irq_n, 1'b1)
      wr(OFF_REQ_STATUS, 32'hff);
   endtask : t_irq
   task automatic t_cmd;
      wr(OFF_CONTROL, 32'h1);
      wr(OFF_SOURCE_EN, 32'h80);
      wr(OFF_OS_COMMAND, 32'h5a);
      cyc(3);
      `CHK(mgmt_irq_n, 1'b0)
      wr(OFF_OS_STATUS, 32'ha5);
      rdchk(OFF_OS_STATUS, 32'ha5);
      wr(OFF_REQ_STATUS, 32'hff);
   endtask : t_cmd
   task automatic t_idle;
      wr(OFF_CONTROL, 32'h11);
      wr(OFF_SOURCE_EN, 32'h40);
      wr(OFF_EVENT_EN, 32'h1);
      wr(OFF_IDLE_START, 32'h2);
      cyc(20);
      `CHK(mgmt_irq_n, 1'b1)
      // System event restarts the count; unreloaded it would fire by now
      pulse(0);
      cyc(30);
      `CHK(mgmt_irq_n, 1'b1)
      cyc(100);
      rdchk(OFF_REQ_STATUS, 32'h40);
      wr(OFF_REQ_STATUS, 32'hff);
   endtask : t_idle
   task automatic t_stop;
      wr(OFF_CONTROL, 32'h2);
      apb(1'b0, OFF_OS_COMMAND, 32'h0);
      cyc(2);
      `CHK({cpu_stop_clock_n, halted}, 2'h1)
      wr(OFF_OS_COMMAND, 32'h0);
      cyc(2);
      `CHK({cpu_stop_clock_n, halted}, 2'h2)
      wr(OFF_EVENT_EN, 32'h100);
      apb(1'b0, OFF_OS_COMMAND, 32'h0);
      pulse(0);
      `CHK(cpu_stop_clock_n, 1'b1)
      apb(1'b0, OFF_OS_COMMAND, 32'h0);
      wr(OFF_CONTROL, 32'h0);
      cyc(2);
      `CHK(cpu_stop_clock_n, 1'b1)
   endtask : t_stop
   task automatic t_scale;
      wr(OFF_NEG_INTERVAL, 32'h2);
      wr(OFF_ASSERT_INTERVAL, 32'h1);
      wr(OFF_CONTROL, 32'h4);
      lowCnt = 0;
      repeat (240)
      begin
         @(posedge clk);
         lowCnt += int'(!cpu_stop_clock_n);
      end
      `CHK(lowCnt inside {[50:110]}, 1'b1)
      wr(OFF_CONTROL, 32'h0);
      wr(OFF_INT_MASK, 32'h7);
      cyc(2);
      `CHK(intReq, 1'b1)
      wr(OFF_INT_MASK, 32'h0);
      cyc(2);
      `CHK(intReq, 1'b0)
      rdchk(OFF_INT_STATUS, 32'h7);
      wr(OFF_INT_STATUS, 32'h7);
      rdchk(OFF_INT_STATUS, 32'h0);
      `CHK(intReq, 1'b0)
   endtask : t_scale
   task automatic report_and_stop;
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_irq();
      t_cmd();
      t_idle();
      t_stop();
      t_scale();
      report_and_stop();
   end
   initial
   begin
      #200000;
      miscompares++;
      report_and_stop();
   end
endmodule : pmsc_top_tb
